// >>> verilog/dio_params.svh
// Offsets, field positions and reset values of the digital I/O block.
// Included by the design modules and by the testbench.
`ifndef DIO_PARAMS_SVH
`define DIO_PARAMS_SVH

`define ADDR_OUT_DATA 12'h000
`define ADDR_IN_DATA 12'h004
`define ADDR_STRAP_STAT 12'h008
`define ADDR_ROUTE_STAT 12'h00c

`define OUT_DATA_RESET 16'h0000

`define STRAP_TRIG_BIT 0
`define STRAP_GATE_BIT 1
`define STRAP_ROUTE_LSB 2
`define STRAP_HOLD_BIT 6

`define ROUTE_TRIG_BIT 0
`define ROUTE_GATE_BIT 1

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// >>> verilog/dio_pkg.sv
// Types shared by the digital I/O block and its bus slave.
// Assumes dio_params.svh is on the include path.
package dio_pkg;

    typedef enum logic [0:0] {
        src_dedicated = 1'b0,
        src_digital_input = 1'b1
    } source_sel_t;

    typedef enum logic [0:0] {
        route_header = 1'b0,
        route_main = 1'b1
    } route_sel_t;

    typedef struct packed {
        logic output_hold_on_hot_reset_strap;
        logic [3:0] output_connector_route_strap;
        source_sel_t gate_src;
        source_sel_t trig_src;
    } strap_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } reg_write_t;

endpackage

// >>> verilog/axil_reg_slave.sv
// AXI4-Lite slave front end: handshakes, one write and one read at a time.
// Assumes the parent decodes addresses and returns data combinationally.
`timescale 1ns/1ps
`include "dio_params.svh"

module axil_reg_slave (
    input wire logic clk,
    input wire logic rst,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output dio_pkg::reg_write_t wr,
    output logic wr_fire,
    input wire logic wr_ok,
    output logic [11:0] rd_addr,
    input wire logic rd_ok,
    input wire logic [31:0] rd_data
);
    import dio_pkg::*;

    logic aw_got_q, aw_got_d, w_got_q, w_got_d;
    logic awready_q, awready_d, wready_q, wready_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic arready_q, arready_d, rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    reg_write_t wr_q, wr_d;

    assign rd_addr = s_axi_araddr;
    assign wr = wr_q;
    assign wr_fire = aw_got_q & w_got_q & ~bvalid_q;

    always_comb begin
        wr_d = wr_q;
        aw_got_d = aw_got_q;
        w_got_d = w_got_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        if (s_axi_awvalid && awready_q) begin
            aw_got_d = 1'b1;
            wr_d.addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q) begin
            w_got_d = 1'b1;
            wr_d.data = s_axi_wdata;
            wr_d.strb = s_axi_wstrb;
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (wr_fire) begin
            aw_got_d = 1'b0;
            w_got_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = wr_ok ? `RESP_OKAY : `RESP_SLVERR;
        end
        awready_d = ~aw_got_d;
        wready_d = ~w_got_d;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_q <= '0;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= `RESP_OKAY;
        end else begin
            wr_q <= wr_d;
            aw_got_q <= aw_got_d;
            w_got_q <= w_got_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
        end
    end

    always_comb begin
        arready_d = arready_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (s_axi_arvalid && arready_q) begin
            arready_d = 1'b0;
            rvalid_d = 1'b1;
            rdata_d = rd_ok ? rd_data : 32'h0000_0000;
            rresp_d = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            arready_d = 1'b1;
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `RESP_OKAY;
        end else begin
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

endmodule // axil_reg_slave

// >>> verilog/dio_strap_port.sv
// Digital output port with hot-reset hold, connector routing and
// strap-selected trigger and gate sources, behind an AXI4-Lite slave.
// Assumes all inputs are synchronous to clk; srst is the power-on reset.
//
// Notes on behaviour
// [RL1] One strap picks the A/D trigger: dedicated trigger pin or input 0.
// [RL2] A second strap picks counter 0 gate: dedicated gate pin or input 2.
// [RL3] Four straps send output lines 0 to 3 to the header or main connector.
// [RL4] A mux daughterboard reads output lines 0 to 3 as its channel code.
// [RL5] 37-pin boards use the main connector, others cable to the header.
// [RL6] With the hold strap set, outputs survive a bus hot reset unchanged.
// [RL7] With the hold strap at default, a bus hot reset clears all outputs.
// [RL8] Power-on reset always brings every output up cleared.
// [RL9] High-gain build: select lines 0-1 float, lines 2-3 tie low on main.
// [RL10] Straps are static inputs sampled every cycle, zero being default.
`timescale 1ns/1ps
`include "dio_params.svh"

module dio_strap_port #(
    parameter int DO_WIDTH = 16,
    parameter int DI_WIDTH = 16,
    parameter bit HIGH_GAIN = 1'b0
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic bus_hot_reset,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire dio_pkg::strap_t straps,
    input wire logic [DI_WIDTH-1:0] digital_in,
    input wire logic external_trigger_pin,
    input wire logic counter_zero_gate_pin,
    output logic [DO_WIDTH-1:0] output_header_20pin_q,
    output logic [DO_WIDTH-1:0] output_header_20pin_oe_q,
    output logic [3:0] main_connector_37pin_q,
    output logic [3:0] main_connector_37pin_oe_q,
    output logic ad_trigger_q,
    output logic counter_zero_gate_q
);
    import dio_pkg::*;

    if (DO_WIDTH < 4 || DO_WIDTH > 16) begin : g_do_check
        $error("DO_WIDTH must lie between 4 and 16");
    end
    if (DI_WIDTH < 3 || DI_WIDTH > 16) begin : g_di_check
        $error("DI_WIDTH must lie between 3 and 16");
    end

    logic slave_rst;
    reg_write_t wr;
    logic wr_fire, wr_ok, rd_ok;
    logic [11:0] rd_addr;
    logic [31:0] rd_data;

    // Bus interface restarts on either reset; data register decides itself
    assign slave_rst = srst | bus_hot_reset;

    axil_reg_slave u_slave (
        .clk(clk),
        .rst(slave_rst),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr(wr),
        .wr_fire(wr_fire),
        .wr_ok(wr_ok),
        .rd_addr(rd_addr),
        .rd_ok(rd_ok),
        .rd_data(rd_data)
    );

    // Straps registered every cycle, never latched once
    strap_t strap_q, strap_d;
    logic [DI_WIDTH-1:0] din_q, din_d;

    always_comb begin
        strap_d = straps; // [RL10]
        din_d = digital_in;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            strap_q <= '0;
            din_q <= '0;
        end else begin
            strap_q <= strap_d;
            din_q <= din_d;
        end
    end

    // Output data register and its reset behaviour
    logic [15:0] out_data_q, out_data_d;

    always_comb begin
        out_data_d = out_data_q;
        if (bus_hot_reset) begin
            if (!strap_q.output_hold_on_hot_reset_strap) begin
                out_data_d = `OUT_DATA_RESET; // [RL7]
            end else begin
                out_data_d = out_data_q; // [RL6]
            end
        end else if (wr_fire && wr_ok &&
                     wr.addr == `ADDR_OUT_DATA) begin
            if (wr.strb[0]) begin
                out_data_d[7:0] = wr.data[7:0];
            end
            if (wr.strb[1]) begin
                out_data_d[15:8] = wr.data[15:8];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            out_data_q <= `OUT_DATA_RESET; // [RL8]
        end else begin
            out_data_q <= out_data_d;
        end
    end

    // Register decode
    always_comb begin
        wr_ok = (wr.addr == `ADDR_OUT_DATA) ||
                (wr.addr == `ADDR_IN_DATA) ||
                (wr.addr == `ADDR_STRAP_STAT) ||
                (wr.addr == `ADDR_ROUTE_STAT);
        rd_ok = 1'b1;
        rd_data = 32'h0000_0000;
        case (rd_addr)
            `ADDR_OUT_DATA: begin
                rd_data[DO_WIDTH-1:0] = out_data_q[DO_WIDTH-1:0];
            end
            `ADDR_IN_DATA: begin
                rd_data[DI_WIDTH-1:0] = din_q;
            end
            `ADDR_STRAP_STAT: begin
                rd_data[`STRAP_HOLD_BIT:0] = strap_q;
            end
            `ADDR_ROUTE_STAT: begin
                rd_data[`ROUTE_TRIG_BIT] = ad_trigger_q;
                rd_data[`ROUTE_GATE_BIT] = counter_zero_gate_q;
            end
            default: begin
                rd_ok = 1'b0;
            end
        endcase
    end

    // Trigger and gate source selection
    logic trig_d, gate_d;

    always_comb begin
        if (strap_q.trig_src == src_digital_input) begin
            trig_d = din_q[0]; // [RL1]
        end else begin
            trig_d = external_trigger_pin; // [RL1]
        end
        if (strap_q.gate_src == src_digital_input) begin
            gate_d = din_q[2]; // [RL2]
        end else begin
            gate_d = counter_zero_gate_pin; // [RL2]
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ad_trigger_q <= 1'b0;
            counter_zero_gate_q <= 1'b0;
        end else begin
            ad_trigger_q <= trig_d;
            counter_zero_gate_q <= gate_d;
        end
    end

    // Per-line routing of outputs 0 to 3 onto the two connectors; higher lines stay on the header
    logic [DO_WIDTH-1:0] hdr_d, hdr_oe_d;
    logic [3:0] main_d, main_oe_d;

    for (genvar i = 0; i < DO_WIDTH; i++) begin : g_line
        if (i < 4) begin : g_routed
            logic to_main;
            assign to_main = strap_q.output_connector_route_strap[i] ==
                             route_main;
            // Header side released when line goes to the main connector
            assign hdr_d[i] = to_main ? 1'b0 : out_data_q[i]; // [RL3]
            assign hdr_oe_d[i] = ~to_main; // [RL3]
            if (HIGH_GAIN && i < 2) begin : g_float
                assign main_d[i] = 1'b0; // [RL9]
                assign main_oe_d[i] = 1'b0; // [RL9]
            end else if (HIGH_GAIN) begin : g_ground
                assign main_d[i] = 1'b0; // [RL9]
                assign main_oe_d[i] = 1'b1; // [RL9]
            end else begin : g_select
                // Channel code for the mux board
                assign main_d[i] = to_main & out_data_q[i]; // [RL3] [RL4]
                assign main_oe_d[i] = to_main; // [RL5]
            end
        end else begin : g_fixed
            assign hdr_d[i] = out_data_q[i];
            assign hdr_oe_d[i] = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            output_header_20pin_q <= '0;
            output_header_20pin_oe_q <= '0;
            main_connector_37pin_q <= 4'h0;
            main_connector_37pin_oe_q <= 4'h0;
        end else begin
            output_header_20pin_q <= hdr_d;
            output_header_20pin_oe_q <= hdr_oe_d;
            main_connector_37pin_q <= main_d;
            main_connector_37pin_oe_q <= main_oe_d;
        end
    end

endmodule // dio_strap_port

// >>> bench/dio_strap_port_monitor.sv
// Checker for the strap port: sources, routing, hot and power-on reset.
// Bound into dio_strap_port; sees only its ports.
`timescale 1ns/1ps
module dio_strap_port_monitor #(
    parameter int DO_WIDTH = 16,
    parameter int DI_WIDTH = 16,
    parameter bit HIGH_GAIN = 1'b0
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic bus_hot_reset,
    input wire dio_pkg::strap_t straps,
    input wire logic [DI_WIDTH-1:0] digital_in,
    input wire logic external_trigger_pin,
    input wire logic counter_zero_gate_pin,
    input wire logic [DO_WIDTH-1:0] output_header_20pin_q,
    input wire logic [DO_WIDTH-1:0] output_header_20pin_oe_q,
    input wire logic [3:0] main_connector_37pin_q,
    input wire logic [3:0] main_connector_37pin_oe_q,
    input wire logic ad_trigger_q,
    input wire logic counter_zero_gate_q
);
    import dio_pkg::*;
    logic [1:0] settle_q;
    logic [1:0] settle_d;
    logic ok;
    logic [3:0] route;
    // Strap to pin path is two registers deep
    always_comb begin
        settle_d = settle_q + {1'b0, settle_q != 2'h3};
        if (srst || bus_hot_reset) begin
            settle_d = 2'h0;
        end
    end
    always_ff @(posedge clk) begin
        settle_q <= settle_d;
    end
    assign ok = settle_q == 2'h3;
    assign route = straps.output_connector_route_strap;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_hot_clear;
        bus_hot_reset && !$past(straps.output_hold_on_hot_reset_strap);
    endsequence
    sequence s_pins_clear;
        output_header_20pin_q == '0 && main_connector_37pin_q == 4'h0;
    endsequence
    // Dedicated pins skip the input register: one cycle, not two
    property p_trig_select;
        ok |-> ad_trigger_q == ($past(straps.trig_src, 2) == src_dedicated
            ? $past(external_trigger_pin) : $past(digital_in[0], 2));
    endproperty
    property p_gate_select;
        ok |-> counter_zero_gate_q == ($past(straps.gate_src, 2)
            == src_dedicated ? $past(counter_zero_gate_pin)
            : $past(digital_in[2], 2));
    endproperty
    // High-gain build: lines 0-1 released, lines 2-3 held low
    property p_route_main;
        ok |-> main_connector_37pin_oe_q
            == (HIGH_GAIN ? 4'hc : $past(route, 2));
    endproperty
    property p_route_header;
        ok |-> output_header_20pin_oe_q[3:0] == ~$past(route, 2);
    endproperty
    property p_released_low;
        (main_connector_37pin_q & ~main_connector_37pin_oe_q) == 4'h0
            && (output_header_20pin_q[3:0]
            & ~output_header_20pin_oe_q[3:0]) == 4'h0;
    endproperty
    property p_hot_clear;
        s_hot_clear |-> ##2 s_pins_clear;
    endproperty
    property p_hot_keep;
        bus_hot_reset && $past(straps.output_hold_on_hot_reset_strap)
            |-> ##2 $stable(output_header_20pin_q);
    endproperty
    property p_por_clear;
        disable iff (1'b0) srst |=> output_header_20pin_q == '0
            && output_header_20pin_oe_q == '0 && !ad_trigger_q;
    endproperty
    a_trig_select: assert property (p_trig_select)
        else $error("trigger source differs from strap");
    a_gate_select: assert property (p_gate_select)
        else $error("gate source differs from strap");
    a_route_main: assert property (p_route_main)
        else $error("main connector enables differ from route");
    a_route_header: assert property (p_route_header)
        else $error("header enables differ from route");
    a_released_low: assert property (p_released_low)
        else $error("released select line carries a value");
    a_hot_clear: assert property (p_hot_clear)
        else $error("outputs not cleared by hot reset");
    a_hot_keep: assert property (p_hot_keep)
        else $error("outputs changed across held hot reset");
    a_por_clear: assert property (p_por_clear)
        else $error("outputs not off after power-on reset");
endmodule // dio_strap_port_monitor

bind dio_strap_port dio_strap_port_monitor #(
    .DO_WIDTH(DO_WIDTH), .DI_WIDTH(DI_WIDTH), .HIGH_GAIN(HIGH_GAIN)
) i_monitor (
    .clk(clk), .srst(srst), .bus_hot_reset(bus_hot_reset),
    .straps(straps), .digital_in(digital_in),
    .external_trigger_pin(external_trigger_pin),
    .counter_zero_gate_pin(counter_zero_gate_pin),
    .output_header_20pin_q(output_header_20pin_q),
    .output_header_20pin_oe_q(output_header_20pin_oe_q),
    .main_connector_37pin_q(main_connector_37pin_q),
    .main_connector_37pin_oe_q(main_connector_37pin_oe_q),
    .ad_trigger_q(ad_trigger_q), .counter_zero_gate_q(counter_zero_gate_q)
);

// >>> bench/mux_daughterboard.sv
// Multiplexer daughterboard reading four channel-select lines.
// Assumes TTL lines with pull-ups: a released line reads high.
`timescale 1ns/1ps
module mux_daughterboard #(
    parameter bit ON_MAIN = 1'b0
) (
    input wire logic [3:0] header_lines,
    input wire logic [3:0] header_oe,
    input wire logic [3:0] main_lines,
    input wire logic [3:0] main_oe,
    output logic [3:0] channel
);
    logic [3:0] hdr_seen;
    logic [3:0] main_seen;
    assign hdr_seen = (header_lines & header_oe) | ~header_oe;
    assign main_seen = (main_lines & main_oe) | ~main_oe;
    // Channel code from the connector this board is cabled to
    assign channel = ON_MAIN ? main_seen : hdr_seen;
endmodule // mux_daughterboard

// >>> bench/dio_reset_hold_and_trigger_select_tb.sv
// Bench of the strap port: source and route table, then resets and bus.
// Assumes dio_params.svh on the include path; checker bound separately.
`timescale 1ns/1ps
`include "dio_params.svh"
module dio_reset_hold_and_trigger_select_tb;
    import dio_pkg::*;
    typedef struct {
        logic [3:0] rt;
        logic [5:0] sig;
        logic [1:0] eq;
    } row_t;
    row_t rows [5];
    logic clk, srst, bus_hot_reset, ext_pin, gate_pin, trig_q, gate_q;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb, main_q, main_oe, hdr_ch, main_ch, rt;
    logic [1:0] bresp, rresp, resp;
    logic [15:0] din, hdr_q, hdr_oe;
    logic [3:0] hg_main_q, hg_main_oe;
    strap_t straps;
    int fail_count, checks_done;

    dio_strap_port #(.DO_WIDTH(16), .DI_WIDTH(16), .HIGH_GAIN(1'b0)) i_dut (
        .clk(clk), .srst(srst), .bus_hot_reset(bus_hot_reset),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .straps(straps),
        .digital_in(din), .external_trigger_pin(ext_pin),
        .counter_zero_gate_pin(gate_pin), .output_header_20pin_q(hdr_q),
        .output_header_20pin_oe_q(hdr_oe), .main_connector_37pin_q(main_q),
        .main_connector_37pin_oe_q(main_oe), .ad_trigger_q(trig_q),
        .counter_zero_gate_q(gate_q)
    );
    // High-gain build on the same stimulus, main connector only
    dio_strap_port #(.DO_WIDTH(16), .DI_WIDTH(16), .HIGH_GAIN(1'b1)) i_dut_hg (
        .clk(clk), .srst(srst), .bus_hot_reset(bus_hot_reset),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(), .s_axi_bresp(),
        .s_axi_bvalid(), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(),
        .s_axi_rvalid(), .s_axi_rready(rready), .straps(straps),
        .digital_in(din), .external_trigger_pin(ext_pin),
        .counter_zero_gate_pin(gate_pin), .output_header_20pin_q(),
        .output_header_20pin_oe_q(), .main_connector_37pin_q(hg_main_q),
        .main_connector_37pin_oe_q(hg_main_oe), .ad_trigger_q(),
        .counter_zero_gate_q()
    );
    mux_daughterboard #(.ON_MAIN(1'b0)) i_hdr_board (
        .header_lines(hdr_q[3:0]), .header_oe(hdr_oe[3:0]),
        .main_lines(main_q), .main_oe(main_oe), .channel(hdr_ch)
    );
    mux_daughterboard #(.ON_MAIN(1'b1)) i_main_board (
        .header_lines(hdr_q[3:0]), .header_oe(hdr_oe[3:0]),
        .main_lines(main_q), .main_oe(main_oe), .channel(main_ch)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        if (fail_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
            input logic [3:0] s, output logic [1:0] r);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic axi_read(input logic [11:0] a, output logic [31:0] d,
            output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic hot_pulse();
        @(posedge clk);
        bus_hot_reset <= 1'b1;
        @(posedge clk);
        bus_hot_reset <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    initial begin
        {srst, bus_hot_reset, ext_pin, gate_pin} = 4'h8;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata, wstrb, din} = '0;
        straps = strap_t'(7'h00);
        fail_count = 0;
        checks_done = 0;
        // Bits: trig sel, gate sel, input 0, input 2, trig pin, gate pin
        rows[0] = '{4'h0, 6'b001101, 2'b01};
        rows[1] = '{4'hf, 6'b101000, 2'b10};
        rows[2] = '{4'h5, 6'b010110, 2'b11};
        rows[3] = '{4'ha, 6'b110011, 2'b00};
        rows[4] = '{4'h0, 6'b111100, 2'b11};
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        axi_write(`ADDR_OUT_DATA, 32'h0000_0003, 4'h3, resp);
        check(32'(resp), 32'(`RESP_OKAY));
        foreach (rows[i]) begin
            rt = rows[i].rt;
            straps <= strap_t'({1'b0, rt, rows[i].sig[4], rows[i].sig[5]});
            din <= {12'h0, ~rows[i].sig[2], rows[i].sig[2],
                ~rows[i].sig[3], rows[i].sig[3]};
            ext_pin <= rows[i].sig[1];
            gate_pin <= rows[i].sig[0];
            repeat (3) @(posedge clk);
            check({30'h0, trig_q, gate_q}, {30'h0, rows[i].eq});
            check({24'h0, main_oe, hdr_oe[3:0]}, {24'h0, rt, ~rt});
            check({24'h0, main_q, hdr_q[3:0]},
                {24'h0, rt & 4'h3, ~rt & 4'h3});
            check({24'h0, main_ch, hdr_ch},
                {24'h0, (rt & 4'h3) | ~rt, (~rt & 4'h3) | rt});
            check({24'h0, hg_main_oe, hg_main_q}, {24'h0, 4'hc, 4'h0});
            axi_read(`ADDR_ROUTE_STAT, rd, resp);
            check(rd, {30'h0, rows[i].eq[0], rows[i].eq[1]});
        end
        axi_write(12'h100, 32'h0000_00ff, 4'hf, resp);
        check(32'(resp), 32'(`RESP_SLVERR));
        axi_read(12'h100, rd, resp);
        check({rd[29:0], resp}, {30'h0, `RESP_SLVERR});
        straps <= strap_t'(7'h00);
        axi_write(`ADDR_OUT_DATA, 32'h0000_a5a5, 4'h3, resp);
        hot_pulse();
        check(32'(hdr_q), 32'h0);
        straps <= strap_t'(7'h40);
        axi_write(`ADDR_OUT_DATA, 32'h0000_5a3c, 4'h3, resp);
        hot_pulse();
        check(32'(hdr_q), 32'h0000_5a3c);
        axi_read(`ADDR_OUT_DATA, rd, resp);
        check(rd, 32'h0000_5a3c);
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        check({hdr_q, hdr_oe}, 32'h0);
        axi_read(`ADDR_OUT_DATA, rd, resp);
        check(rd, 32'h0);
        stop_test();
    end

    initial begin
        repeat (3000) @(posedge clk);
        fail_count++;
        stop_test();
    end
endmodule // dio_reset_hold_and_trigger_select_tb
